// ### atm_cell_delineation_rx.v
// cell delineation receiver: header check, delineation fsm, idle discard, descrambler, axi4-lite registers
`timescale 1ns/1ps
`include "atm_cell_delineation_rx_consts.vh"
module atm_cell_delineation_rx (
    input wire i_clk_sys,
    input wire i_resetn,
    input wire [7:0] i_data,
    input wire i_data_en,
    output reg [7:0] o_data,
    output reg o_data_valid,
    output reg o_soc,
    output reg o_cell_received,
    output reg o_cell_discard,
    output reg o_delineation_lost_flag,
    input wire [7:0] i_s_axi_awaddr,
    input wire i_s_axi_awvalid,
    output reg o_s_axi_awready,
    input wire [31:0] i_s_axi_wdata,
    input wire [3:0] i_s_axi_wstrb,
    input wire i_s_axi_wvalid,
    output reg o_s_axi_wready,
    output reg [1:0] o_s_axi_bresp,
    output reg o_s_axi_bvalid,
    input wire i_s_axi_bready,
    input wire [7:0] i_s_axi_araddr,
    input wire i_s_axi_arvalid,
    output reg o_s_axi_arready,
    output reg [31:0] o_s_axi_rdata,
    output reg [1:0] o_s_axi_rresp,
    output reg o_s_axi_rvalid,
    input wire i_s_axi_rready
);

localparam [1:0] ST_HUNT = 2'd0;
localparam [1:0] ST_PRESYNC = 2'd1;
localparam [1:0] ST_CORR = 2'd2;
localparam [1:0] ST_DET = 2'd3;

////////////////////////////////////////////////////////////////////////////////
// header check helpers

function [7:0] hec_crc;
    input [31:0] d;
    integer i;
    reg [7:0] c;
    reg fb;
    begin
        c = 8'h00;
        for (i = 31; i >= 0; i = i - 1) begin
            fb = c[7] ^ d[i];
            c = {c[6:0], 1'b0};
            if (fb) begin
                c = c ^ `HEC_POLY;
            end
        end
        hec_crc = c;
    end
endfunction

// syndrome of each single-bit error, searched at elaboration-friendly cost
function [39:0] corr_mask_of;
    input [7:0] syn;
    integer i;
    reg [39:0] e;
    reg [39:0] m;
    begin
        m = 40'h0000000000;
        for (i = 0; i < 40; i = i + 1) begin
            e = 40'h0000000001 << i;
            if (syn == (hec_crc(e[39:8]) ^ e[7:0])) begin
                m = e;
            end
        end
        corr_mask_of = m;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// declarations

reg [7:0] buf_r [0:`BUF_DEPTH-1];
reg [5:0] cnt_r;
reg [1:0] state_r;
reg [1:0] state_nxt;
reg [3:0] good_r;
reg [3:0] good_nxt;
reg [2:0] bad_r;
reg [2:0] bad_nxt;
reg cnt_clr;
reg deliver;
reg discard;
reg use_mask;
reg cell_ok_r;
reg [31:0] mask_r;
reg [`DSCR_LEN-1:0] dscr_r;
reg [`DSCR_LEN-1:0] dscr_nxt;
reg [7:0] dsc_byte;
reg [7:0] hdr_mbyte;
reg corr_en_r;
reg [15:0] disc_cnt_r;
reg [15:0] recv_cnt_r;
reg aw_got_r;
reg w_got_r;
reg [7:0] awaddr_r;
reg [31:0] wdata_r;
reg [3:0] wstrb_r;
integer k;
integer m;

wire [39:0] hdr_win = {buf_r[7], buf_r[6], buf_r[5], buf_r[4], buf_r[3]};
wire [7:0] syndrome = hec_crc(hdr_win[39:8]) ^ hdr_win[7:0] ^ `HEC_COSET;
wire header_check_fail = |syndrome;
wire [39:0] corr_mask = corr_mask_of(syndrome);
wire single_err = |corr_mask;
wire hdr_expected = (cnt_r == `LAST_IDX);
// idle test runs on the corrected header, so a one-bit hit on an idle header is still dropped
wire [31:0] hdr_fixed = hdr_win[39:8] ^ (use_mask ? corr_mask[39:8] : 32'h00000000);
wire idle_hit = (hdr_fixed == `IDLE_HDR);
wire is_pay = (cnt_r >= `PAY_FIRST);
wire in_sync = (state_r == ST_CORR) || (state_r == ST_DET);

////////////////////////////////////////////////////////////////////////////////
// delineation state machine

always @* begin
    state_nxt = state_r;
    good_nxt = good_r;
    bad_nxt = bad_r;
    cnt_clr = 1'b0;
    deliver = 1'b0;
    discard = 1'b0;
    use_mask = 1'b0;
    case (state_r)
        ST_HUNT: begin
            // every octet position is tried as a header
            if (!header_check_fail) begin
                state_nxt = ST_PRESYNC;
                // restart the count so the matched header lands on octet 0
                cnt_clr = 1'b1;
                good_nxt = 4'd0;
            end
        end
        ST_PRESYNC: begin
            if (hdr_expected) begin
                if (header_check_fail) begin
                    state_nxt = ST_HUNT;
                end else if (good_r == `PRESYNC_GOOD - 4'd1) begin
                    state_nxt = ST_CORR;
                    good_nxt = 4'd0;
                end else begin
                    good_nxt = good_r + 4'd1;
                end
            end
        end
        ST_CORR: begin
            if (hdr_expected) begin
                if (!header_check_fail) begin
                    deliver = 1'b1;
                end else begin
                    // a corrected header still counts as the first bad one
                    state_nxt = ST_DET;
                    good_nxt = 4'd0;
                    bad_nxt = 3'd1;
                    if (corr_en_r && single_err) begin
                        deliver = 1'b1;
                        use_mask = 1'b1;
                    end else begin
                        discard = 1'b1;
                    end
                end
            end
        end
        ST_DET: begin
            // no correction here: any error means discard
            // a good header breaks the bad run and a bad one the good run
            if (hdr_expected) begin
                if (!header_check_fail) begin
                    deliver = 1'b1;
                    bad_nxt = 3'd0;
                    if (good_r == `DET_GOOD - 4'd1) begin
                        state_nxt = ST_CORR;
                        good_nxt = 4'd0;
                    end else begin
                        good_nxt = good_r + 4'd1;
                    end
                end else begin
                    discard = 1'b1;
                    good_nxt = 4'd0;
                    if (bad_r == `DET_BAD - 3'd1) begin
                        state_nxt = ST_HUNT;
                    end else begin
                        bad_nxt = bad_r + 3'd1;
                    end
                end
            end
        end
        default: begin
            state_nxt = ST_HUNT;
        end
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// output byte shaping

always @* begin
    dscr_nxt = dscr_r;
    // history holds received payload bits only, msb first
    for (m = 7; m >= 0; m = m - 1) begin
        dsc_byte[m] = buf_r[8][m] ^ dscr_nxt[`DSCR_LEN-1];
        dscr_nxt = {dscr_nxt[`DSCR_LEN-2:0], buf_r[8][m]};
    end
    case (cnt_r[1:0])
        2'd0: hdr_mbyte = mask_r[31:24];
        2'd1: hdr_mbyte = mask_r[23:16];
        2'd2: hdr_mbyte = mask_r[15:8];
        default: hdr_mbyte = mask_r[7:0];
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// cell stream, one step per qualified cycle

always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
        for (k = 0; k < `BUF_DEPTH; k = k + 1) begin
            buf_r[k] <= 8'h00;
        end
        cnt_r <= 6'd0;
        state_r <= ST_HUNT;
        good_r <= 4'd0;
        bad_r <= 3'd0;
        cell_ok_r <= 1'b0;
        mask_r <= 32'h00000000;
        dscr_r <= {`DSCR_LEN{1'b0}};
        o_data <= 8'h00;
        o_data_valid <= 1'b0;
        o_soc <= 1'b0;
        o_cell_received <= 1'b0;
        o_cell_discard <= 1'b0;
        o_delineation_lost_flag <= 1'b1;
        disc_cnt_r <= 16'h0000;
        recv_cnt_r <= 16'h0000;
    end else if (i_data_en) begin
        // a low qualifier freezes pipeline, counter and descrambler alike
        buf_r[0] <= i_data;
        for (k = 1; k < `BUF_DEPTH; k = k + 1) begin
            buf_r[k] <= buf_r[k-1];
        end
        if (cnt_clr || hdr_expected) begin
            cnt_r <= 6'd0;
        end else begin
            cnt_r <= cnt_r + 6'd1;
        end
        state_r <= state_nxt;
        good_r <= good_nxt;
        bad_r <= bad_nxt;
        if (hdr_expected || state_r == ST_HUNT) begin
            cell_ok_r <= deliver && !idle_hit;
            // mask holds for the whole cell, only header octets use it
            mask_r <= use_mask ? corr_mask[39:8] : 32'h00000000;
        end
        // descrambler tracks payload even when cells are dropped, so it stays locked
        if (is_pay) begin
            dscr_r <= dscr_nxt;
        end
        o_data <= is_pay ? dsc_byte : (buf_r[8] ^ hdr_mbyte);
        o_data_valid <= cell_ok_r && in_sync && (cnt_r != `HEC_IDX);
        o_soc <= cell_ok_r && in_sync && (cnt_r == 6'd0);
        o_cell_received <= cell_ok_r && in_sync && (cnt_r == `LAST_IDX);
        o_cell_discard <= discard;
        o_delineation_lost_flag <= !((state_nxt == ST_CORR) || (state_nxt == ST_DET));
        if (discard) begin
            disc_cnt_r <= disc_cnt_r + 16'h0001;
        end
        if (cell_ok_r && in_sync && (cnt_r == `LAST_IDX)) begin
            recv_cnt_r <= recv_cnt_r + 16'h0001;
        end
    end else begin
        // pulses last one clock even when the qualifier stays low
        o_data_valid <= 1'b0;
        o_soc <= 1'b0;
        o_cell_received <= 1'b0;
        o_cell_discard <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite write channel, one write in flight

always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready <= 1'b1;
        o_s_axi_bvalid <= 1'b0;
        o_s_axi_bresp <= `RESP_OKAY;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        awaddr_r <= 8'h00;
        wdata_r <= 32'h00000000;
        wstrb_r <= 4'h0;
        corr_en_r <= `CTRL_CORR_RESET;
    end else begin
        if (o_s_axi_awready && i_s_axi_awvalid) begin
            awaddr_r <= i_s_axi_awaddr;
            aw_got_r <= 1'b1;
            o_s_axi_awready <= 1'b0;
        end
        if (o_s_axi_wready && i_s_axi_wvalid) begin
            wdata_r <= i_s_axi_wdata;
            wstrb_r <= i_s_axi_wstrb;
            w_got_r <= 1'b1;
            o_s_axi_wready <= 1'b0;
        end
        if (aw_got_r && w_got_r && !o_s_axi_bvalid) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            case (awaddr_r)
                `REG_CTRL: begin
                    o_s_axi_bresp <= `RESP_OKAY;
                    // only bit 0 is stored, the other control bits read back as zero
                    if (wstrb_r[0]) begin
                        corr_en_r <= wdata_r[0];
                    end
                end
                // read-only registers ignore writes but answer okay
                `REG_STATUS, `REG_DISC_CNT, `REG_RECV_CNT: begin
                    o_s_axi_bresp <= `RESP_OKAY;
                end
                default: begin
                    o_s_axi_bresp <= `RESP_SLVERR;
                end
            endcase
        end
        if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite read channel

always @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
        o_s_axi_arready <= 1'b1;
        o_s_axi_rvalid <= 1'b0;
        o_s_axi_rdata <= 32'h00000000;
        o_s_axi_rresp <= `RESP_OKAY;
    end else begin
        if (o_s_axi_arready && i_s_axi_arvalid) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b1;
            o_s_axi_rresp <= `RESP_OKAY;
            // status and counters are captured at the address handshake
            case (i_s_axi_araddr)
                `REG_CTRL: o_s_axi_rdata <= {31'h0, corr_en_r};
                `REG_STATUS: o_s_axi_rdata <= {29'h0, o_delineation_lost_flag, state_r};
                `REG_DISC_CNT: o_s_axi_rdata <= {16'h0000, disc_cnt_r};
                `REG_RECV_CNT: o_s_axi_rdata <= {16'h0000, recv_cnt_r};
                default: begin
                    o_s_axi_rdata <= 32'h00000000;
                    o_s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end
        if (o_s_axi_rvalid && i_s_axi_rready) begin
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_arready <= 1'b1;
        end
    end
end

endmodule // atm_cell_delineation_rx

// ### atm_cell_delineation_rx_checker.sv
// concurrent checks on the cell output side of the delineation receiver
`timescale 1ns/1ps
module atm_cell_delineation_rx_checker (
    input wire i_clk_sys,
    input wire i_resetn,
    input wire i_data_en,
    input wire [7:0] o_data,
    input wire o_data_valid,
    input wire o_soc,
    input wire o_cell_received,
    input wire o_cell_discard,
    input wire o_delineation_lost_flag
);
    // valid octets delivered since the last start of cell
    reg [5:0] vcnt_r;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////////////////////////////
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            vcnt_r <= 6'd0;
        end else if (o_data_valid) begin
            vcnt_r <= o_soc ? 6'd1 : vcnt_r + 6'd1;
        end
    end
    ////////////////////////////////////////////////////////////////
    lost_no_valid_a: assert property (o_delineation_lost_flag |-> !o_data_valid && !o_soc)
        else $error("valid data while delineation lost");
    soc_start_a: assert property (o_soc |-> o_data_valid && (vcnt_r == 6'd0 || vcnt_r == 6'd52))
        else $error("start of cell inside a cell");
    rcv_count_a: assert property (o_cell_received |-> o_data_valid && !o_soc && vcnt_r == 6'd51)
        else $error("cell received not on octet 52");
    rcv_pulse_a: assert property (o_cell_received |=> !o_cell_received)
        else $error("cell received wider than one clock");
    disc_pulse_a: assert property (o_cell_discard |=> !o_cell_discard)
        else $error("discard wider than one clock");
    disc_sync_a: assert property (o_cell_discard |-> !$past(o_delineation_lost_flag) && !o_soc)
        else $error("discard outside sync");
    qual_out_a: assert property ((o_data_valid || o_cell_discard) |-> $past(i_data_en))
        else $error("output event on unqualified cycle");
    hold_data_a: assert property (!$past(i_data_en) |-> $stable(o_data))
        else $error("output octet moved without qualifier");
endmodule // atm_cell_delineation_rx_checker

bind atm_cell_delineation_rx atm_cell_delineation_rx_checker chk_u (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_data_en(i_data_en), .o_data(o_data), .o_data_valid(o_data_valid), .o_soc(o_soc),
    .o_cell_received(o_cell_received), .o_cell_discard(o_cell_discard),
    .o_delineation_lost_flag(o_delineation_lost_flag));

// ### atm_cell_delineation_rx_consts.vh
// constants for the atm cell delineation receiver
`ifndef ATM_CELL_DELINEATION_RX_CONSTS_VH
`define ATM_CELL_DELINEATION_RX_CONSTS_VH
`define BUF_DEPTH 9
`define LAST_IDX 6'd52
`define HEC_IDX 6'd4
`define PAY_FIRST 6'd5
`define PRESYNC_GOOD 4'd6
`define DET_GOOD 4'd8
`define DET_BAD 3'd7
`define HEC_COSET 8'h55
`define HEC_POLY 8'h07
`define IDLE_HDR 32'h00000001
`define DSCR_LEN 43
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DISC_CNT 8'h08
`define REG_RECV_CNT 8'h0c
`define CTRL_CORR_RESET 1'b1
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ### atm_cell_delineation_rx_tb.sv
// self-checking bench for the cell delineation receiver
`timescale 1ns/1ps
`include "atm_cell_delineation_rx_consts.vh"
module atm_cell_delineation_rx_tb;
    localparam [31:0] GH = 32'h12345670;
    localparam [39:0] E1 = 40'h0800000000;
    localparam [39:0] E2 = 40'h0000030000;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg hold = 1'b1;
    reg busy = 1'b0;
    reg [31:0] hdr = 32'h0;
    reg [39:0] err = 40'h0;
    reg [7:0] awa = 8'h00, ara = 8'h00;
    reg [31:0] wd = 32'h0;
    reg [3:0] ws = 4'hf;
    reg awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    wire [7:0] sd, od;
    wire sen, last, ov, soc, rcv, disc, lost, awr, wr, bv, arr, rv;
    wire [1:0] br, rr;
    wire [31:0] rd;
    integer n_fail = 0, comparisons = 0, cyc = 0, n_rcv = 0, n_disc = 0, k = 0, r0, d0;
    always #12.5 clk = ~clk;
    cell_source_model src_u (.i_clk_sys(clk), .i_resetn(rstn), .i_hold(hold), .i_hdr(hdr), .i_err(err),
        .o_data(sd), .o_data_en(sen), .o_last(last));
    atm_cell_delineation_rx dut_u (.i_clk_sys(clk), .i_resetn(rstn), .i_data(sd), .i_data_en(sen),
        .o_data(od), .o_data_valid(ov), .o_soc(soc), .o_cell_received(rcv), .o_cell_discard(disc),
        .o_delineation_lost_flag(lost), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv), .o_s_axi_awready(awr),
        .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws), .i_s_axi_wvalid(wv), .o_s_axi_wready(wr), .o_s_axi_bresp(br),
        .o_s_axi_bvalid(bv), .i_s_axi_bready(bry), .i_s_axi_araddr(ara), .i_s_axi_arvalid(arv),
        .o_s_axi_arready(arr), .o_s_axi_rdata(rd), .o_s_axi_rresp(rr), .o_s_axi_rvalid(rv), .i_s_axi_rready(rry));
    ////////////////////////////////////////////////////////////////
    task wrap_up;
        begin
            $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            comparisons = comparisons + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task axr(input [7:0] a, input [31:0] e, input [1:0] er);
        begin
            ara <= a;
            arv <= 1'b1;
            rry <= 1'b1;
            busy = 1'b1;
            while (busy) begin
                @(posedge clk);
                if (arr === 1'b1) arv <= 1'b0;
                if (rv === 1'b1) begin
                    rry <= 1'b0;
                    busy = 1'b0;
                    chk(rd, e);
                    chk(rr, er);
                end
            end
            // one idle edge so rready is never lowered and raised in one step
            @(posedge clk);
        end
    endtask
    task axw(input [7:0] a, input [31:0] d);
        begin
            awa <= a;
            wd <= d;
            awv <= 1'b1;
            wv <= 1'b1;
            bry <= 1'b1;
            busy = 1'b1;
            while (busy) begin
                @(posedge clk);
                if (awr === 1'b1) awv <= 1'b0;
                if (wr === 1'b1) wv <= 1'b0;
                if (bv === 1'b1) begin
                    bry <= 1'b0;
                    busy = 1'b0;
                    chk(br, `RESP_OKAY);
                end
            end
            @(posedge clk);
        end
    endtask
    // delivered-cell deltas lag one cell: a cell emerges during the next call
    task cells(input integer n, input [31:0] h, input [39:0] e, input integer er, input integer ed);
        begin
            hdr <= h;
            err <= e;
            hold <= 1'b0;
            r0 = n_rcv;
            d0 = n_disc;
            repeat (n) @(posedge last);
            hold <= 1'b1;
            repeat (2) @(posedge clk);
            if (er >= 0) chk(n_rcv - r0, er);
            chk(n_disc - d0, ed);
            $display("cells done t=%0t", $time);
        end
    endtask
    function [7:0] exp_b(input integer i);
        begin
            exp_b = (i < 4) ? GH[31 - 8 * i -: 8] : ({2'b00, i[5:0] + 6'd1} ^ 8'ha5);
        end
    endfunction
    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 12000) begin
            n_fail = n_fail + 1;
            wrap_up;
        end
        n_rcv = n_rcv + (rcv === 1'b1);
        n_disc = n_disc + (disc === 1'b1);
        if (ov === 1'b1) begin
            k = (soc === 1'b1) ? 0 : k + 1;
            chk(od, exp_b(k));
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        axr(`REG_CTRL, 32'h1, `RESP_OKAY);
        axr(`REG_STATUS, 32'h4, `RESP_OKAY);
        axr(8'h10, 32'h0, `RESP_SLVERR);
        cells(8, GH, 40'h0, 0, 0);
        axr(`REG_STATUS, 32'h2, `RESP_OKAY);
        chk(lost, 1'b0);
        cells(3, GH, 40'h0, 3, 0);
        cells(2, `IDLE_HDR, 40'h0, 1, 0);
        cells(1, GH, E1, 0, 0);
        axr(`REG_STATUS, 32'h3, `RESP_OKAY);
        cells(1, GH, E1, 1, 1);
        cells(7, GH, 40'h0, 6, 0);
        axr(`REG_STATUS, 32'h3, `RESP_OKAY);
        cells(1, GH, 40'h0, 1, 0);
        axr(`REG_STATUS, 32'h2, `RESP_OKAY);
        axw(`REG_CTRL, 32'h0);
        cells(1, GH, E1, 1, 1);
        axw(`REG_CTRL, 32'h1);
        axr(`REG_CTRL, 32'h1, `RESP_OKAY);
        cells(8, GH, 40'h0, 7, 0);
        cells(6, GH, E2, 1, 6);
        axr(`REG_STATUS, 32'h3, `RESP_OKAY);
        cells(1, GH, E2, 0, 1);
        axr(`REG_STATUS, 32'h4, `RESP_OKAY);
        chk(lost, 1'b1);
        axw(`REG_RECV_CNT, 32'hffff);
        axr(`REG_DISC_CNT, 32'd9, `RESP_OKAY);
        axr(`REG_RECV_CNT, 32'd21, `RESP_OKAY);
        cells(9, GH, 40'h0, -1, 0);
        axr(`REG_STATUS, 32'h2, `RESP_OKAY);
        wrap_up;
    end
endmodule // atm_cell_delineation_rx_tb

// ### cell_source_model.sv
// upstream framer model: scrambled 53-octet cells with idle gaps
`timescale 1ns/1ps
module cell_source_model (
    input wire i_clk_sys,
    input wire i_resetn,
    input wire i_hold,
    input wire [31:0] i_hdr,
    input wire [39:0] i_err,
    output reg [7:0] o_data,
    output reg o_data_en,
    output reg o_last
);
    reg [5:0] cnt_r;
    reg [39:0] hdr_r;
    reg [42:0] scr_r;
    reg [42:0] s;
    reg [1:0] cyc_r;
    reg [7:0] b;
    integer i;
    function [7:0] hec(input [31:0] h);
        integer j;
        begin
            hec = 8'h00;
            for (j = 31; j >= 0; j = j - 1) hec = {hec[6:0], 1'b0} ^ ((hec[7] ^ h[j]) ? 8'h07 : 8'h00);
            hec = hec ^ 8'h55;
        end
    endfunction
    // scrambled payload octet for the current count
    always @* begin
        b = {2'b00, cnt_r} ^ 8'ha5;
        s = scr_r;
        for (i = 7; i >= 0; i = i - 1) begin
            b[i] = b[i] ^ s[42];
            s = {s[41:0], b[i]};
        end
    end
    ////////////////////////////////////////////////////////////////
    always @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_r <= 6'd0;
            hdr_r <= 40'h0;
            scr_r <= 43'h0;
            cyc_r <= 2'd0;
            o_data <= 8'h00;
            o_data_en <= 1'b0;
            o_last <= 1'b0;
        end else begin
            cyc_r <= cyc_r + 2'd1;
            o_data_en <= !(i_hold || cyc_r == 2'd3);
            if (i_hold || cyc_r == 2'd3) begin
                // idle line flips every bit each cycle rather than holding the last octet
                o_data <= ~o_data;
            end else begin
                cnt_r <= (cnt_r == 6'd52) ? 6'd0 : cnt_r + 6'd1;
                o_last <= (cnt_r == 6'd52);
                if (cnt_r == 6'd0) begin
                    hdr_r <= {i_hdr, hec(i_hdr)} ^ i_err;
                    o_data <= i_hdr[31:24] ^ i_err[39:32];
                end else if (cnt_r < 6'd5) begin
                    o_data <= hdr_r[39 - 8 * cnt_r -: 8];
                end else begin
                    o_data <= b;
                    scr_r <= s;
                end
            end
        end
    end
endmodule // cell_source_model
